/* File: verilog/tpg_consts.svh */
// Register indices, field positions, reset values and counts of the test pattern generator
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH
`define TPG_IDX_CTRL      8'h64
`define TPG_IDX_CFG       8'h65
`define TPG_IDX_IADDR     8'h66
`define TPG_IDX_IDATA     8'h67
`define TPG_IDX_STAT      8'h68
`define TPG_CTRL_RST      8'h10
`define TPG_CFG_RST       8'h00
`define TPG_IADDR_RST     8'h00
`define TPG_IND_RST       8'h00
`define TPG_CTRL_MASK     8'hf7
`define TPG_CFG_MASK      8'h7f
`define TPG_CTRL_EN       0
`define TPG_CTRL_REV      1
`define TPG_CTRL_BARS     2
`define TPG_CTRL_SEL      7:4
`define TPG_CFG_SCALE     6
`define TPG_CFG_CUSTOM    5
`define TPG_CFG_REDUCED   4
`define TPG_CFG_EXTCLK    3
`define TPG_CFG_TSEL      2
`define TPG_CFG_INVERT    1
`define TPG_CFG_SCROLL    0
`define TPG_IND_DEPTH     32
`define TPG_IND_LIMIT     8'h20
`define TPG_IND_AW        5
`define TPG_I_HTOT_LO     0
`define TPG_I_HTOT_HI     1
`define TPG_I_VTOT_LO     2
`define TPG_I_VTOT_HI     3
`define TPG_I_HACT_LO     4
`define TPG_I_HACT_HI     5
`define TPG_I_VACT_LO     6
`define TPG_I_VACT_HI     7
`define TPG_I_HSW         8
`define TPG_I_VSW         9
`define TPG_I_HBP         10
`define TPG_I_VBP         11
`define TPG_I_SYNC        12
`define TPG_I_CUST_R      13
`define TPG_I_CUST_G      14
`define TPG_I_CUST_B      15
`define TPG_I_PEN_LO      16
`define TPG_I_PEN_HI      17
`define TPG_I_DWELL       18
`define TPG_SYNC_HNEG     0
`define TPG_SYNC_VNEG     1
`define TPG_DIV_LAST      4'h1
`define TPG_LEV_FULL      13'h0100
`define TPG_LEV_RED       13'h0040
`define TPG_CELL_FINE     0
`define TPG_CELL_SCALED   3
`define TPG_SEEK_MAX      5'h10
`define TPG_FULL          8'hff
`define TPG_NONE          8'h00
`define TPG_RED_MASK      8'hfc
`define TPG_PAT_CHECK     4'h0
`define TPG_PAT_WHITE     4'h1
`define TPG_PAT_BLACK     4'h2
`define TPG_PAT_RED       4'h3
`define TPG_PAT_GREEN     4'h4
`define TPG_PAT_BLUE      4'h5
`define TPG_PAT_HGREY     4'h6
`define TPG_PAT_HRED      4'h7
`define TPG_PAT_HGREEN    4'h8
`define TPG_PAT_HBLUE     4'h9
`define TPG_PAT_VGREY     4'ha
`define TPG_PAT_VRED      4'hb
`define TPG_PAT_VGREEN    4'hc
`define TPG_PAT_VBLUE     4'hd
`endif

/* File: verilog/tpg_pkg.sv */
// Types of the test pattern generator
package tpg_pkg;
  typedef enum logic [1:0] {
    TPG_IDLE = 2'b00,
    TPG_SEEK = 2'b01
  } tpg_scroll_type;

  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
  } tpg_sync_type;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } tpg_rgb_type;

  typedef struct packed {
    tpg_sync_type sync;
    tpg_rgb_type  rgb;
  } tpg_video_type;

  typedef struct packed {
    logic           ready;
    logic           err;
    logic [31:0]    rdata;
    logic [7:0]     ctrl;
    logic [7:0]     cfg;
    logic [7:0]     iaddr;
    logic [2:0]     pclk_s;
    logic [2:0]     de_s;
    logic [2:0]     hs_s;
    logic [2:0]     vs_s;
    logic [3:0]     div_cnt;
    logic [11:0]    hcnt;
    logic [11:0]    vcnt;
    logic [11:0]    x;
    logic [11:0]    y;
    logic [11:0]    hfrac;
    logic [11:0]    vfrac;
    logic [7:0]     hlev;
    logic [7:0]     vlev;
    logic [7:0]     frame_cnt;
    logic [3:0]     cur_pat;
    tpg_scroll_type scroll;
    logic [4:0]     seek_n;
    tpg_sync_type   prev;
    tpg_video_type  video;
  } tpg_state_type;
endpackage

/* File: verilog/tpg_ind_mem.sv */
// Indirectly mapped pattern register file with registered read port
`timescale 1ns/10ps
`include "tpg_consts.svh"
module tpg_ind_mem
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // Write port
  input  wire logic                         wr_en,
  input  wire logic [7:0]                   waddr,
  input  wire logic [7:0]                   wdata,
  // Read port
  input  wire logic [7:0]                   raddr,
  output logic      [7:0]                   rdata,
  // All cells side by side, for the timing and colour logic
  output logic      [`TPG_IND_DEPTH*8-1:0]  contents
);
  logic [`TPG_IND_DEPTH-1:0][7:0] cells;

  genvar i;
  generate
    for (i = 0; i < `TPG_IND_DEPTH; i++) begin : g_cell
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cells[i] <= `TPG_IND_RST;
        end else if (wr_en && waddr == 8'(i)) begin
          cells[i] <= wdata;
        end
      end
    end
  endgenerate

  // Addresses past the last cell read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= `TPG_IND_RST;
    end else if (raddr < `TPG_IND_LIMIT) begin
      rdata <= cells[raddr[`TPG_IND_AW-1:0]];
    end else begin
      rdata <= `TPG_NONE;
    end
  end

  assign contents = cells;
endmodule

/* File: verilog/tpg_top.sv */
// Test pattern generator: configuration, indirect access, timing and pattern drawing
//
// Contract
// - Checkerboard and alternating panel squares are 8x8 pixels when scaling is set, else 1x1.
// - With the custom bit set the checkerboard alternates the custom colour and black, else white.
// - Reduced depth gives ramp patterns 64 brightness steps, full depth gives 256.
// - Reduced depth drives each colour channel from its six upper bits only.
// - With internal timing the pixel rate is the external pixel clock if bit 3 is set, else a divider.
// - The clock source bit has no effect while external timing is selected.
// - With timing select clear the generator follows the incoming pixel clock, enable and syncs.
// - With timing select set the generator makes its own frame from the programmed sizes and syncs.
// - With automatic scroll clear the current pattern is kept indefinitely.
// - With automatic scroll set the next enabled pattern follows after the dwell count of frames.
// - The 8-bit indirect address picks which indirect register a data access reaches.
// - A write of the indirect data delivers the byte to the register picked by the address.
// - A read of the indirect data returns the register picked by the address.
// - The fixed pattern select is ignored while scrolling, and pixels appear only when enabled.
`timescale 1ns/10ps
`include "tpg_consts.svh"
module tpg_top
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Incoming video timing pins
  input  wire logic        ext_pclk,
  input  wire logic        ext_de,
  input  wire logic        ext_hs,
  input  wire logic        ext_vs,
  // Pattern output
  output tpg_video_type    video
);
  tpg_state_type              st;
  tpg_state_type              next_st;
  logic [7:0]                 idx;
  logic                       access;
  logic                       ind_we;
  logic [7:0]                 ind_q;
  logic [`TPG_IND_DEPTH*8-1:0] ind;
  logic [11:0]                htot;
  logic [11:0]                vtot;
  logic [11:0]                hact;
  logic [11:0]                vact;
  logic [7:0]                 hsw;
  logic [7:0]                 vsw;
  logic [7:0]                 hbp;
  logic [7:0]                 vbp;
  logic [7:0]                 sync_cfg;
  tpg_rgb_type                cust;
  logic [15:0]                pat_en;
  logic [7:0]                 dwell;
  logic                       internal;
  logic                       ext_edge;
  logic                       div_tick;
  logic                       tick;
  tpg_sync_type               raw;
  logic                       frame_start;
  logic                       line_end;
  logic [3:0]                 pattern;
  logic [12:0]                lev_step;
  logic [12:0]                hsum;
  logic [12:0]                vsum;
  logic [12:0]                hstart;
  logic [12:0]                hend;
  logic [12:0]                vstart;
  logic [12:0]                vend;
  logic                       cell_on;
  logic [1:0]                 panel;
  logic [7:0]                 hl;
  logic [7:0]                 vl;
  tpg_rgb_type                pix;

  assign idx    = paddr[9:2];
  assign access = psel && penable && !st.ready;
  assign ind_we = access && pwrite && idx == `TPG_IDX_IDATA;

  // Indirect cells: address picks the cell for both writes and reads
  tpg_ind_mem tpg_ind_mem_i (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (ind_we),
    .waddr    (st.iaddr),
    .wdata    (pwdata[7:0]),
    .raddr    (st.iaddr),
    .rdata    (ind_q),
    .contents (ind)
  );

  assign htot     = {ind[`TPG_I_HTOT_HI*8 +: 4], ind[`TPG_I_HTOT_LO*8 +: 8]};
  assign vtot     = {ind[`TPG_I_VTOT_HI*8 +: 4], ind[`TPG_I_VTOT_LO*8 +: 8]};
  assign hact     = {ind[`TPG_I_HACT_HI*8 +: 4], ind[`TPG_I_HACT_LO*8 +: 8]};
  assign vact     = {ind[`TPG_I_VACT_HI*8 +: 4], ind[`TPG_I_VACT_LO*8 +: 8]};
  assign hsw      = ind[`TPG_I_HSW*8 +: 8];
  assign vsw      = ind[`TPG_I_VSW*8 +: 8];
  assign hbp      = ind[`TPG_I_HBP*8 +: 8];
  assign vbp      = ind[`TPG_I_VBP*8 +: 8];
  assign sync_cfg = ind[`TPG_I_SYNC*8 +: 8];
  assign cust     = {ind[`TPG_I_CUST_R*8 +: 8], ind[`TPG_I_CUST_G*8 +: 8],
                     ind[`TPG_I_CUST_B*8 +: 8]};
  assign pat_en   = {ind[`TPG_I_PEN_HI*8 +: 8], ind[`TPG_I_PEN_LO*8 +: 8]};
  assign dwell    = ind[`TPG_I_DWELL*8 +: 8];

  // Pixel rate: synced pin edge or internal divider
  assign internal = st.cfg[`TPG_CFG_TSEL];
  assign ext_edge = st.pclk_s[1] && !st.pclk_s[2];
  assign div_tick = st.div_cnt == `TPG_DIV_LAST;
  assign tick     = (internal && !st.cfg[`TPG_CFG_EXTCLK]) ? div_tick : ext_edge;

  assign hstart = 13'({hbp} + {hsw});
  assign hend   = hstart + {1'b0, hact};
  assign vstart = 13'({vbp} + {vsw});
  assign vend   = vstart + {1'b0, vact};

  always_comb begin
    if (internal) begin
      raw.de = {1'b0, st.hcnt} >= hstart && {1'b0, st.hcnt} < hend &&
               {1'b0, st.vcnt} >= vstart && {1'b0, st.vcnt} < vend;
      raw.hs = (st.hcnt < {4'h0, hsw}) ^ sync_cfg[`TPG_SYNC_HNEG];
      raw.vs = (st.vcnt < {4'h0, vsw}) ^ sync_cfg[`TPG_SYNC_VNEG];
    end else begin
      raw = {st.de_s[1], st.hs_s[1], st.vs_s[1]};
    end
  end

  assign frame_start = tick && raw.vs && !st.prev.vs;
  assign line_end    = tick && !raw.de && st.prev.de;
  assign lev_step    = st.cfg[`TPG_CFG_REDUCED] ? `TPG_LEV_RED : `TPG_LEV_FULL;
  assign hsum        = {1'b0, st.hfrac} + lev_step;
  assign vsum        = {1'b0, st.vfrac} + lev_step;

  // Pattern drawing from the pixel coordinates and the ramp levels
  assign pattern = st.cfg[`TPG_CFG_SCROLL] ? st.cur_pat : st.ctrl[`TPG_CTRL_SEL];
  assign hl      = st.cfg[`TPG_CFG_REDUCED] ? {st.hlev[5:0], 2'b00} : st.hlev;
  assign vl      = st.cfg[`TPG_CFG_REDUCED] ? {st.vlev[5:0], 2'b00} : st.vlev;

  always_comb begin
    tpg_rgb_type c;
    logic        cx;
    logic        cy;
    c  = '0;
    cx = st.cfg[`TPG_CFG_SCALE] ? st.x[`TPG_CELL_SCALED] : st.x[`TPG_CELL_FINE];
    cy = st.cfg[`TPG_CFG_SCALE] ? st.y[`TPG_CELL_SCALED] : st.y[`TPG_CELL_FINE];
    cell_on = cx ^ cy;
    panel   = {cy, cx} ^ {2{st.ctrl[`TPG_CTRL_REV]}};
    if (st.ctrl[`TPG_CTRL_BARS]) begin
      c.r = {8{~st.hlev[6]}};
      c.g = {8{~st.hlev[7]}};
      c.b = {8{~st.hlev[5]}};
    end else begin
      case (pattern)
        `TPG_PAT_CHECK: begin
          if (cell_on) begin
            c = st.cfg[`TPG_CFG_CUSTOM] ? cust : {3{`TPG_FULL}};
          end
        end
        `TPG_PAT_WHITE:  c = {3{`TPG_FULL}};
        `TPG_PAT_BLACK:  c = '0;
        `TPG_PAT_RED:    c.r = `TPG_FULL;
        `TPG_PAT_GREEN:  c.g = `TPG_FULL;
        `TPG_PAT_BLUE:   c.b = `TPG_FULL;
        `TPG_PAT_HGREY:  c = {hl, hl, hl};
        `TPG_PAT_HRED:   c.r = hl;
        `TPG_PAT_HGREEN: c.g = hl;
        `TPG_PAT_HBLUE:  c.b = hl;
        `TPG_PAT_VGREY:  c = {vl, vl, vl};
        `TPG_PAT_VRED:   c.r = vl;
        `TPG_PAT_VGREEN: c.g = vl;
        `TPG_PAT_VBLUE:  c.b = vl;
        default: begin
          // Alternating panel: yellow, cyan, blue, red per square
          case (panel)
            2'b00:   c = {`TPG_FULL, `TPG_FULL, `TPG_NONE};
            2'b01:   c = {`TPG_NONE, `TPG_FULL, `TPG_FULL};
            2'b10:   c = {`TPG_NONE, `TPG_NONE, `TPG_FULL};
            default: c = {`TPG_FULL, `TPG_NONE, `TPG_NONE};
          endcase
        end
      endcase
    end
    if (st.cfg[`TPG_CFG_INVERT]) begin
      c = ~c;
    end
    if (st.cfg[`TPG_CFG_REDUCED]) begin
      c = c & {3{`TPG_RED_MASK}};
    end
    pix = c;
  end

  always_comb begin
    next_st = st;
    // APB: one wait state, answer in the second access cycle
    next_st.ready = access;
    next_st.err   = 1'b0;
    next_st.rdata = '0;
    if (access) begin
      case (idx)
        `TPG_IDX_CTRL: begin
          next_st.rdata = {24'h000000, st.ctrl};
          if (pwrite) next_st.ctrl = pwdata[7:0] & `TPG_CTRL_MASK;
        end
        `TPG_IDX_CFG: begin
          next_st.rdata = {24'h000000, st.cfg};
          if (pwrite) next_st.cfg = pwdata[7:0] & `TPG_CFG_MASK;
        end
        `TPG_IDX_IADDR: begin
          next_st.rdata = {24'h000000, st.iaddr};
          if (pwrite) next_st.iaddr = pwdata[7:0];
        end
        `TPG_IDX_IDATA: next_st.rdata = {24'h000000, ind_q};
        `TPG_IDX_STAT: next_st.rdata = {24'h000000, 1'b0, st.scroll == TPG_SEEK,
                                        st.video.sync.de, st.video.sync.vs, st.cur_pat};
        default: next_st.err = 1'b1;
      endcase
    end
    // Pin synchronisers; logic reads only stages 1 and 2
    next_st.pclk_s  = {st.pclk_s[1:0], ext_pclk};
    next_st.de_s    = {st.de_s[1:0], ext_de};
    next_st.hs_s    = {st.hs_s[1:0], ext_hs};
    next_st.vs_s    = {st.vs_s[1:0], ext_vs};
    next_st.div_cnt = div_tick ? '0 : st.div_cnt + 4'h1;
    if (tick) begin
      if (!internal) begin
        next_st.hcnt = '0;
        next_st.vcnt = '0;
      end else if (st.hcnt + 12'h001 >= htot) begin
        next_st.hcnt = '0;
        next_st.vcnt = (st.vcnt + 12'h001 >= vtot) ? '0 : st.vcnt + 12'h001;
      end else begin
        next_st.hcnt = st.hcnt + 12'h001;
      end
      next_st.prev = raw;
      if (raw.de) begin
        next_st.x = st.x + 12'h001;
        if (hsum >= {1'b0, hact}) begin
          next_st.hfrac = 12'(hsum - {1'b0, hact});
          next_st.hlev  = st.hlev + 8'h01;
        end else begin
          next_st.hfrac = hsum[11:0];
        end
      end else begin
        next_st.x     = '0;
        next_st.hfrac = '0;
        next_st.hlev  = '0;
      end
      if (frame_start) begin
        next_st.y     = '0;
        next_st.vfrac = '0;
        next_st.vlev  = '0;
      end else if (line_end) begin
        next_st.y = st.y + 12'h001;
        if (vsum >= {1'b0, vact}) begin
          next_st.vfrac = 12'(vsum - {1'b0, vact});
          next_st.vlev  = st.vlev + 8'h01;
        end else begin
          next_st.vfrac = vsum[11:0];
        end
      end
      next_st.video.sync = raw;
      next_st.video.rgb  = (raw.de && st.ctrl[`TPG_CTRL_EN]) ? pix : '0;
    end
    if (!st.cfg[`TPG_CFG_SCROLL]) begin
      next_st.frame_cnt = '0;
      next_st.scroll    = TPG_IDLE;
    end else begin
      case (st.scroll)
        TPG_IDLE: begin
          if (frame_start) begin
            if (st.frame_cnt + 8'h01 >= dwell) begin
              next_st.frame_cnt = '0;
              next_st.seek_n    = '0;
              next_st.scroll    = TPG_SEEK;
            end else begin
              next_st.frame_cnt = st.frame_cnt + 8'h01;
            end
          end
        end
        TPG_SEEK: begin
          next_st.cur_pat = st.cur_pat + 4'h1;
          next_st.seek_n  = st.seek_n + 5'h01;
          if (pat_en[st.cur_pat + 4'h1] || st.seek_n + 5'h01 == `TPG_SEEK_MAX) begin
            next_st.scroll = TPG_IDLE;
          end
        end
        default: next_st.scroll = TPG_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= '0;
      st.ctrl  <= `TPG_CTRL_RST;
      st.cfg   <= `TPG_CFG_RST;
      st.iaddr <= `TPG_IADDR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.rdata;
  assign pready  = st.ready;
  assign pslverr = st.err;
  assign video   = st.video;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered after one wait state");
  ind_write_a: assert property (pready && psel && pwrite && idx == `TPG_IDX_IDATA &&
      st.iaddr < `TPG_IND_LIMIT |=> ind_q == $past(pwdata[7:0]))
    else $error("Indirect write did not reach the addressed cell");
  ind_read_a: assert property (pready && idx == `TPG_IDX_IDATA && !pwrite |->
      prdata == {24'h000000, $past(ind_q)})
    else $error("Indirect read returned the wrong cell");
  reduced_depth_a: assert property (tick && st.cfg[`TPG_CFG_REDUCED] |=>
      video.rgb.r[1:0] == 2'b00 && video.rgb.g[1:0] == 2'b00 && video.rgb.b[1:0] == 2'b00)
    else $error("Reduced depth pixel uses low colour bits");
  ext_follow_a: assert property (tick && !internal |=>
      video.sync == {$past(st.de_s[1]), $past(st.hs_s[1]), $past(st.vs_s[1])})
    else $error("External timing not followed");
  clk_source_a: assert property (internal && st.cfg[`TPG_CFG_EXTCLK] |->
      tick == (st.pclk_s[1] && !st.pclk_s[2]))
    else $error("Pixel rate taken from the wrong source");
  div_rate_a: assert property (tick && internal && !st.cfg[`TPG_CFG_EXTCLK] |=>
      !tick || !internal || st.cfg[`TPG_CFG_EXTCLK])
    else $error("Divided pixel rate ticked twice in a row");
  ext_mode_clk_a: assert property (!internal |-> tick == (st.pclk_s[1] && !st.pclk_s[2]))
    else $error("Clock source bit acted in external timing mode");
  hold_pattern_a: assert property (!st.cfg[`TPG_CFG_SCROLL] |=> $stable(st.cur_pat))
    else $error("Pattern changed with scrolling off");
  seek_bound_a: assert property (st.scroll == TPG_SEEK |-> ##[1:16] st.scroll == TPG_IDLE)
    else $error("Scroll search did not end");
  checker_cell_a: assert property (tick && raw.de && st.ctrl[`TPG_CTRL_EN] &&
      pattern == `TPG_PAT_CHECK && st.cfg[7:1] == 7'h00 && !st.ctrl[`TPG_CTRL_BARS] |=>
      video.rgb.g == (($past(st.x[0]) ^ $past(st.y[0])) ? `TPG_FULL : `TPG_NONE))
    else $error("Unscaled checkerboard square wrong");
  disabled_black_a: assert property (tick && !st.ctrl[`TPG_CTRL_EN] |=> video.rgb == '0)
    else $error("Pixels output while disabled");

  scroll_c: cover property (st.scroll == TPG_SEEK ##[1:16] st.scroll == TPG_IDLE);
  ind_read_c: cover property (pready && !pwrite && idx == `TPG_IDX_IDATA);
  frame_c: cover property (internal && frame_start);
  checker_c: cover property (tick && raw.de && pattern == `TPG_PAT_CHECK && cell_on);
endmodule

/* File: verif/tpg_video_src.sv */
// Free-running external video timing source feeding the pattern generator
`timescale 1ns/10ps
module tpg_video_src (
  // Video timing pins
  output logic ext_pclk,
  output logic ext_de,
  output logic ext_hs,
  output logic ext_vs
);
  logic [3:0] x;
  logic [2:0] y;

  initial begin
    ext_pclk = 1'b0;
    x = 4'h0;
    y = 3'h0;
    {ext_de, ext_hs, ext_vs} = 3'h0;
    #37;
    forever #300 ext_pclk = ~ext_pclk;
  end

  // Outputs move on the falling edge so they are steady at each pixel rise
  always @(negedge ext_pclk) begin
    x <= (x == 4'hd) ? 4'h0 : x + 4'h1;
    if (x == 4'hd)
      y <= (y == 3'h5) ? 3'h0 : y + 3'h1;
    ext_de <= (x >= 4'h2) && (x < 4'ha) && (y >= 3'h1) && (y < 3'h5);
    ext_hs <= (x == 4'h0);
    ext_vs <= (y == 3'h0);
  end
endmodule

/* File: verif/test_pattern_generator_config_bench.sv */
// Self-checking bench: register access, indirect cells and pattern output
`timescale 1ns/10ps
`include "tpg_consts.svh"
module test_pattern_generator_config_bench
  import tpg_pkg::*;
;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [31:0]   pwdata = 32'h00000000;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          ext_pclk;
  logic          ext_de;
  logic          ext_hs;
  logic          ext_vs;
  tpg_video_type video;
  int            mismatches = 0;
  int            total_checks = 0;
  logic [31:0]   rd;
  logic          err;
  tpg_rgb_type   px;

  localparam logic [7:0] ind_val [0:18] = '{8'h14, 8'h00, 8'h06, 8'h00, 8'h08, 8'h00, 8'h02,
    8'h00, 8'h02, 8'h01, 8'h02, 8'h01, 8'h00, 8'h12, 8'h34, 8'h56, 8'hff, 8'h3f, 8'h02};
  localparam logic [7:0] cfg_v [0:15] = '{8'h00, 8'h02, 8'h10, 8'h12, 8'h00, 8'h08, 8'h04,
    8'h0c, 8'h00, 8'h40, 8'h20, 8'h40, 8'h00, 8'h00, 8'h10, 8'h00};
  localparam logic [7:0] ctl_v [0:15] = '{8'h31, 8'h31, 8'h31, 8'h31, 8'h30, 8'h11, 8'h31,
    8'h41, 8'h01, 8'h01, 8'h01, 8'hf1, 8'hf3, 8'ha1, 8'ha1, 8'h05};
  localparam logic [23:0] rgb_v [0:15] = '{24'hff0000, 24'h00ffff, 24'hfc0000, 24'h00fcfc,
    24'h000000, 24'hffffff, 24'hff0000, 24'h00ff00, 24'hffffff, 24'h000000, 24'h123456,
    24'hffff00, 24'h00ffff, 24'h010101, 24'h040404, 24'hffffff};
  // Levels awaited in turn: vs low, vs high, de high, de low, de high
  localparam logic [4:0]  wait_lvl = 5'b10110;
  localparam logic [7:0] rst_v [0:3] = '{`TPG_CTRL_RST, `TPG_CFG_RST, `TPG_IADDR_RST, 8'h00};

  always #50 pclk = ~pclk;

  tpg_top tpg_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pclk(ext_pclk), .ext_de(ext_de), .ext_hs(ext_hs), .ext_vs(ext_vs), .video(video)
  );

  tpg_video_src tpg_video_src_i (
    .ext_pclk(ext_pclk), .ext_de(ext_de), .ext_hs(ext_hs), .ext_vs(ext_vs)
  );

  task automatic results();
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= {2'b00, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      results();
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask

  // First pixel of the second active line after the next frame start
  task automatic line_pixel();
    int n;
    n = 0;
    for (int s = 0; s < 5; s++) begin
      do begin
        @(posedge pclk);
        n++;
      end while ((s < 2 ? video.sync.vs : video.sync.de) !== wait_lvl[s] && n < 3000);
    end
    px = video.rgb;
    if (n >= 3000) begin
      mismatches++;
      results();
    end
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_chk(`TPG_IDX_CTRL + 8'(i), rst_v[i]);
    end
    apb(1'b1, `TPG_IDX_CFG, 8'hff);
    rd_chk(`TPG_IDX_CFG, 8'h7f);
    for (int i = 0; i < 19; i++) begin
      apb(1'b1, `TPG_IDX_IADDR, 8'(i));
      apb(1'b1, `TPG_IDX_IDATA, ind_val[i]);
    end
    for (int i = 0; i < 19; i++) begin
      apb(1'b1, `TPG_IDX_IADDR, 8'(i));
      rd_chk(`TPG_IDX_IDATA, ind_val[i]);
    end
    apb(1'b1, `TPG_IDX_IADDR, `TPG_IND_LIMIT);
    apb(1'b1, `TPG_IDX_IDATA, 8'h55);
    rd_chk(`TPG_IDX_IDATA, 8'h00);
    rd_chk(`TPG_IDX_IADDR, `TPG_IND_LIMIT);
    apb(1'b0, 8'h70, 8'h00);
    chk(rd, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    apb(1'b1, `TPG_IDX_STAT, 8'hff);
    chk({31'h0, err}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, `TPG_IDX_CFG, cfg_v[i]);
      apb(1'b1, `TPG_IDX_CTRL, ctl_v[i]);
      line_pixel();
      chk({8'h00, px}, {8'h00, rgb_v[i]});
    end
    apb(1'b1, `TPG_IDX_CTRL, 8'h31);
    line_pixel();
    chk({8'h00, px}, 32'h00ff0000);
    apb(1'b1, `TPG_IDX_CFG, 8'h21);
    line_pixel();
    chk({8'h00, px}, 32'h00123456);
    line_pixel();
    chk({8'h00, px}, 32'h00ffffff);
    apb(1'b1, `TPG_IDX_CFG, 8'h20);
    line_pixel();
    chk({8'h00, px}, 32'h00ff0000);
    apb(1'b0, `TPG_IDX_STAT, 8'h00);
    chk(rd & 32'h0000000f, 32'h00000001);
    results();
  end
endmodule
